/* verilog/sarcc_control.sv */
// Notes on behaviour
// - rising convert_start ends acquisition and starts conversion.
// - fourteen binary-weighted trials, most significant bit decided first.
// - after last trial return to acquisition, publish code, signal completion.
// - conversion timed by own clock; serial clock plays no part.
// - up to 250 kSPS; converter powered only while converting.
// - unipolar ranges give straight binary codes.
// - bipolar ranges give fourteen-bit twos complement codes.
// - overrange saturates to 0x3fff unipolar, 0x1fff bipolar.
// - underrange saturates to 0x0000 unipolar, 0x2000 bipolar.
// - fourteen-bit configuration word shifted in serially and applied.
// - result readable during or after next conversion, config optionally appended.
// - delivered result is the latest completed conversion, no pipeline.
// - convert_start held high through conversion enables busy on data output.
// - serial data moves msb first, timed by host serial clock.
module sarcc_control import sarcc_pkg::*; #(
  parameter int TRIALS = RES_BITS,
  parameter int TRIAL_LEN = TRIAL_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic convertStart,
  input wire logic sck,
  input wire logic sdi,
  output logic sdo,
  output logic sdoEn,
  input wire logic compAbove,
  input wire logic overRange,
  input wire logic underRange,
  output logic [RES_BITS-1:0] dacCode,
  output logic trackEn,
  output logic convPowerEn,
  output logic busy,
  output logic convDone,
  output logic [CFG_BITS-1:0] cfgWord,
  output logic [RES_BITS-1:0] resultCode
);
  // ==========================================
  // convert_start synchroniser
  logic [2:0] cnvSync_q;
  logic cnvLvl_q;
  logic cnvRise;
  logic cnvFall;

  // first stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnvSync_q <= 3'h0;
    end else begin
      cnvSync_q <= {cnvSync_q[1:0], convertStart};
    end
  end

  assign cnvRise = (cnvSync_q[1] == cnvSync_q[2]) && cnvSync_q[2] && !cnvLvl_q;
  assign cnvFall = (cnvSync_q[1] == cnvSync_q[2]) && !cnvSync_q[2] && cnvLvl_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnvLvl_q <= 1'b0;
    end else if (cnvSync_q[1] == cnvSync_q[2]) begin
      cnvLvl_q <= cnvSync_q[2];
    end
  end

  // ==========================================
  // serial port
  sarcc_port_if lnk ();
  logic [RES_BITS-1:0] result_q;
  logic [CFG_BITS-1:0] resultCfg_q;

  sarcc_serial u_serial (
    .clk(clk),
    .rst_n(rst_n),
    .sck(sck),
    .sdi(sdi),
    .lnk(lnk.port)
  );

  // frame opens when convert_start falls; mid-conversion it reads the prior result
  assign lnk.frameLoad = cnvFall;
  assign lnk.resultWord = result_q;
  assign lnk.appendWord = resultCfg_q;
  assign lnk.appendEn = !resultCfg_q[CFG_READBACK_BIT];
  assign cfgWord = lnk.cfgWord;

  // ==========================================
  // sequencer
  sarcc_state_t state_q;
  logic [3:0] bitIdx_q;
  logic [7:0] trialCnt_q;
  logic [RES_BITS-1:0] sar_q;
  logic bipolar_q;
  logic trialEnd;
  logic lastTrial;

  assign trialEnd = (state_q == SAR_CONV) && (trialCnt_q == 8'(TRIAL_LEN - 1));
  assign lastTrial = (bitIdx_q == 4'h0);

  // a new rise while converting is ignored; host must wait for completion
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= SAR_ACQ;
    end else begin
      case (state_q)
        SAR_ACQ: begin
          if (cnvRise) begin
            state_q <= SAR_CONV;
          end
        end
        SAR_CONV: begin
          if (trialEnd && lastTrial) begin
            state_q <= SAR_ACQ;
          end
        end
        default: begin
          state_q <= SAR_ACQ;
        end
      endcase
    end
  end

  // trial pacing from the core clock alone, no serial clock needed
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trialCnt_q <= 8'h0;
    end else if (state_q != SAR_CONV || trialEnd) begin
      trialCnt_q <= 8'h0;
    end else begin
      trialCnt_q <= trialCnt_q + 8'h1;
    end
  end

  // successive approximation: set trial bit, keep it if comparator says above
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sar_q <= '0;
      bitIdx_q <= 4'h0;
    end else if (state_q == SAR_ACQ && cnvRise) begin
      sar_q <= SAR_FIRST_CODE;
      bitIdx_q <= 4'(TRIALS - 1);
    end else if (trialEnd) begin
      sar_q[bitIdx_q] <= compAbove;
      if (!lastTrial) begin
        sar_q[bitIdx_q - 4'h1] <= 1'b1;
        bitIdx_q <= bitIdx_q - 4'h1;
      end
    end
  end

  // range and readback come from the word in force when sampling ended
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bipolar_q <= 1'b0;
    end else if (state_q == SAR_ACQ && cnvRise) begin
      bipolar_q <= !lnk.cfgWord[CFG_RANGE_BIT];
    end
  end

  // ==========================================
  // output coding and result register
  logic [RES_BITS-1:0] finalRaw;
  logic [RES_BITS-1:0] coded;
  logic [CFG_BITS-1:0] convCfg_q;

  assign finalRaw = {sar_q[RES_BITS-1:1], compAbove};

  // saturation first, then offset binary turned into twos complement
  always_comb begin
    if (overRange) begin
      coded = bipolar_q ? BIP_MAX_CODE : UNI_MAX_CODE;
    end else if (underRange) begin
      coded = bipolar_q ? BIP_MIN_CODE : UNI_MIN_CODE;
    end else if (bipolar_q) begin
      coded = finalRaw ^ BIP_FLIP_MASK;
    end else begin
      coded = finalRaw;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      convCfg_q <= CFG_RESET;
    end else if (state_q == SAR_ACQ && cnvRise) begin
      convCfg_q <= lnk.cfgWord;
    end
  end

  // only a completed conversion replaces the held result
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      result_q <= UNI_MIN_CODE;
      resultCfg_q <= CFG_RESET;
    end else if (trialEnd && lastTrial) begin
      result_q <= coded;
      resultCfg_q <= convCfg_q;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      convDone <= 1'b0;
    end else begin
      convDone <= trialEnd && lastTrial;
    end
  end

  // ==========================================
  // busy indication on the data output
  logic busyMode_q;
  logic readyHigh_q;

  // busy mode survives only if convert_start stays high throughout
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busyMode_q <= 1'b0;
      readyHigh_q <= 1'b0;
    end else begin
      if (state_q == SAR_ACQ && cnvRise) begin
        busyMode_q <= 1'b1;
      end else if (cnvFall || (trialEnd && lastTrial)) begin
        busyMode_q <= 1'b0;
      end
      // completion wins over a same-cycle clear so a finished result is never hidden
      if (trialEnd && lastTrial && busyMode_q) begin
        readyHigh_q <= 1'b1;
      end else if (cnvFall || cnvRise) begin
        readyHigh_q <= 1'b0;
      end
    end
  end

  // low while busy, high when done, result bits once convert_start is low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sdo <= 1'b0;
      sdoEn <= 1'b0;
    end else if (!cnvLvl_q) begin
      sdo <= lnk.sdoBit;
      sdoEn <= 1'b1;
    end else if (busyMode_q && state_q == SAR_CONV) begin
      sdo <= 1'b0;
      sdoEn <= 1'b1;
    end else begin
      sdo <= readyHigh_q;
      sdoEn <= readyHigh_q;
    end
  end

  // ==========================================
  // analog side controls
  assign dacCode = sar_q;
  assign trackEn = (state_q == SAR_ACQ);
  assign convPowerEn = (state_q == SAR_CONV);
  assign busy = (state_q == SAR_CONV);
  assign resultCode = result_q;
endmodule : sarcc_control

/* verilog/sarcc_pkg.sv */
package sarcc_pkg;
  // ==========================================
  // word sizes
  localparam int RES_BITS = 14;
  localparam int CFG_BITS = 14;
  localparam int OUT_BITS = RES_BITS + CFG_BITS;

  // ==========================================
  // output codes
  localparam logic [13:0] UNI_MAX_CODE = 14'h3fff;
  localparam logic [13:0] UNI_MIN_CODE = 14'h0000;
  localparam logic [13:0] BIP_MAX_CODE = 14'h1fff;
  localparam logic [13:0] BIP_MIN_CODE = 14'h2000;
  localparam logic [13:0] SAR_FIRST_CODE = 14'h2000;
  localparam logic [13:0] BIP_FLIP_MASK = 14'h2000;

  // ==========================================
  // configuration word
  localparam logic [13:0] CFG_RESET = 14'h3fff;
  localparam int CFG_RANGE_BIT = 12;
  localparam int CFG_READBACK_BIT = 0;

  // ==========================================
  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int SAMPLE_RATE_SPS = 250000;
  localparam int SAMPLE_PERIOD_NS = 1000000000 / SAMPLE_RATE_SPS;
  localparam int CONV_TIME_NS = 3000;
  localparam int CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;
  localparam int TRIAL_CYCLES = (CONV_CYCLES / RES_BITS) < 1 ? 1 : (CONV_CYCLES / RES_BITS);

  // ==========================================
  // sequencer states
  typedef enum logic [1:0] {
    SAR_ACQ = 2'b01,
    SAR_CONV = 2'b10
  } sarcc_state_t;
endpackage : sarcc_pkg

/* verilog/sarcc_port_if.sv */
interface sarcc_port_if;
  import sarcc_pkg::*;
  logic frameLoad;
  logic [RES_BITS-1:0] resultWord;
  logic [CFG_BITS-1:0] appendWord;
  logic appendEn;
  logic sdoBit;
  logic [CFG_BITS-1:0] cfgWord;
  logic cfgStrobe;

  modport ctrl (
    output frameLoad,
    output resultWord,
    output appendWord,
    output appendEn,
    input sdoBit,
    input cfgWord,
    input cfgStrobe
  );
  modport port (
    input frameLoad,
    input resultWord,
    input appendWord,
    input appendEn,
    output sdoBit,
    output cfgWord,
    output cfgStrobe
  );
endinterface : sarcc_port_if

/* verilog/sarcc_serial.sv */
module sarcc_serial import sarcc_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sck,
  input wire logic sdi,
  sarcc_port_if.port lnk
);
  // ==========================================
  // pin synchronisers
  logic [2:0] sckSync_q;
  logic [2:0] sdiSync_q;
  logic sckLvl_q;
  logic sckRise;
  logic sckFall;

  // three stages; only stages two and three are looked at
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sckSync_q <= 3'h0;
      sdiSync_q <= 3'h0;
    end else begin
      sckSync_q <= {sckSync_q[1:0], sck};
      sdiSync_q <= {sdiSync_q[1:0], sdi};
    end
  end

  // edge counts once stages two and three agree
  assign sckRise = (sckSync_q[1] == sckSync_q[2]) && sckSync_q[2] && !sckLvl_q;
  assign sckFall = (sckSync_q[1] == sckSync_q[2]) && !sckSync_q[2] && sckLvl_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sckLvl_q <= 1'b0;
    end else if (sckSync_q[1] == sckSync_q[2]) begin
      sckLvl_q <= sckSync_q[2];
    end
  end

  // ==========================================
  // result shifter, msb first
  logic [OUT_BITS-1:0] outShift_q;

  // appended word only when readback is on; zeros follow otherwise
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      outShift_q <= '0;
    end else if (lnk.frameLoad) begin
      outShift_q <= {lnk.resultWord, lnk.appendEn ? lnk.appendWord : {CFG_BITS{1'b0}}};
    end else if (sckFall) begin
      outShift_q <= {outShift_q[OUT_BITS-2:0], 1'b0};
    end
  end

  assign lnk.sdoBit = outShift_q[OUT_BITS-1];

  // ==========================================
  // configuration shifter
  logic [CFG_BITS-1:0] inShift_q;
  logic [4:0] inCnt_q;
  logic [CFG_BITS-1:0] cfgWord_q;
  logic cfgStrobe_q;

  // bits past the fourteenth are ignored until the next frame
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      inShift_q <= '0;
      inCnt_q <= 5'h0;
    end else if (lnk.frameLoad) begin
      inCnt_q <= 5'h0;
    end else if (sckRise && inCnt_q < 5'(CFG_BITS)) begin
      inShift_q <= {inShift_q[CFG_BITS-2:0], sdiSync_q[2]};
      inCnt_q <= inCnt_q + 5'h1;
    end
  end

  // whole word applied at once, never a partial one
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfgWord_q <= CFG_RESET;
      cfgStrobe_q <= 1'b0;
    end else begin
      cfgStrobe_q <= 1'b0;
      if (sckRise && inCnt_q == 5'(CFG_BITS - 1)) begin
        cfgWord_q <= {inShift_q[CFG_BITS-2:0], sdiSync_q[2]};
        cfgStrobe_q <= 1'b1;
      end
    end
  end

  assign lnk.cfgWord = cfgWord_q;
  assign lnk.cfgStrobe = cfgStrobe_q;
endmodule : sarcc_serial

/* tb/sarcc_control_chk.sv */
module sarcc_control_chk import sarcc_pkg::*; #(
  parameter int TRIALS = RES_BITS,
  parameter int TRIAL_LEN = TRIAL_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic convertStart,
  input wire logic overRange,
  input wire logic underRange,
  input wire logic [RES_BITS-1:0] dacCode,
  input wire logic trackEn,
  input wire logic convPowerEn,
  input wire logic busy,
  input wire logic convDone,
  input wire logic [CFG_BITS-1:0] cfgWord,
  input wire logic [RES_BITS-1:0] resultCode
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  int busyLen_q;
  logic uniRange_q;
  // ==========================================
  // range as taken at the start edge; config may be rewritten mid-conversion
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      uniRange_q <= 1'b1;
    end else if (!busy) begin
      uniRange_q <= cfgWord[CFG_RANGE_BIT];
    end
  end
  // ==========================================
  // busy length, read back when busy falls
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) busyLen_q <= 0;
    else busyLen_q <= busy ? busyLen_q + 1 : 0;
  end
  // ==========================================
  // properties
  AST_START_TAKEN: assert property ($rose(convertStart) && trackEn |-> ##[1:6] busy)
    else $error("start edge not taken");
  AST_FIRST_TRIAL: assert property ($rose(busy) |-> dacCode == SAR_FIRST_CODE)
    else $error("first trial not msb");
  AST_TRACK: assert property (trackEn == !busy)
    else $error("track and busy overlap");
  AST_POWER: assert property (convPowerEn == busy)
    else $error("power outside conversion");
  AST_CONV_LEN: assert property ($fell(busy) |-> busyLen_q >= TRIALS * TRIAL_LEN - 1 && busyLen_q <= TRIALS * TRIAL_LEN + 1)
    else $error("conversion length wrong");
  AST_DONE: assert property ($fell(busy) |-> convDone ##1 !convDone)
    else $error("done pulse wrong");
  AST_HOLD: assert property (!$fell(busy) |-> $stable(resultCode))
    else $error("result changed outside completion");
  AST_OVER: assert property ($fell(busy) && $past(overRange) |-> resultCode == (uniRange_q ? UNI_MAX_CODE : BIP_MAX_CODE))
    else $error("overrange code wrong");
  AST_UNDER: assert property ($fell(busy) && $past(underRange) && !$past(overRange) |-> resultCode == (uniRange_q ? UNI_MIN_CODE : BIP_MIN_CODE))
    else $error("underrange code wrong");
  COV_OVER: cover property ($fell(busy) && $past(overRange));
  COV_BIP: cover property ($fell(busy) && !uniRange_q);
  COV_DONE: cover property (convDone);
endmodule : sarcc_control_chk

bind sarcc_control sarcc_control_chk #(.TRIALS(TRIALS), .TRIAL_LEN(TRIAL_LEN)) i_chk (.clk, .rst_n, .convertStart,
  .overRange, .underRange, .dacCode, .trackEn, .convPowerEn, .busy, .convDone, .cfgWord, .resultCode);

/* tb/sarcc_host.sv */
module sarcc_host (
  input wire logic clk,
  input wire logic busy,
  input wire logic sdo,
  output logic convertStart,
  output logic sck,
  output logic sdi
);
  timeunit 1ns;
  timeprecision 1ns;
  // sck rests low outside frames, conversions never need it
  initial begin
    convertStart = 1'b0;
    sck = 1'b0;
    sdi = 1'b0;
  end
  // ==========================================
  // host actions
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : tick
  task automatic startConv(output bit ok);
    int i;
    ok = 0;
    convertStart = 1'b1;
    for (i = 0; i < 12 && !ok; i++) begin
      tick(1);
      ok = (busy === 1'b1);
    end
  endtask : startConv
  // bounded wait for completion before any new start
  task automatic waitDone(output bit ok);
    int i;
    ok = (busy === 1'b0);
    for (i = 0; i < 2000 && !ok; i++) begin
      tick(1);
      ok = (busy === 1'b0);
    end
  endtask : waitDone
  // 28 bits; slow sck so the pin filter never drops an edge
  task automatic frame(input logic [13:0] cfgIn, output logic [27:0] rd);
    int i;
    convertStart = 1'b0;
    tick(8);
    for (i = 27; i >= 0; i--) begin
      rd[i] = sdo;
      sdi = (i >= 14) ? cfgIn[i-14] : ~sdi;
      tick(1);
      sck = 1'b1;
      tick(5);
      sck = 1'b0;
      tick(6);
    end
  endtask : frame
endmodule : sarcc_host

/* tb/sar_conversion_control_tb_top.sv */
module sar_conversion_control_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import sarcc_pkg::*;
  localparam int TL = 2;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic convertStart, sck, sdi, sdo, sdoEn, compAbove, overRange, underRange;
  logic trackEn, convPowerEn, busy, convDone;
  logic [13:0] dacCode, cfgWord, resultCode, expRes, prevRes, cfgCur, cfgPrev, nextCfg;
  logic [27:0] rd, rdExp;
  int num_errors, check_count, sample, cycles, i;
  bit ok, hold;
  logic [13:0] expQ[$];

  // comparator: kept bit when the held sample reaches the trial code
  assign compAbove = (int'(dacCode) <= sample);

  sarcc_control #(.TRIAL_LEN(TL)) i_dut (.clk, .rst_n, .convertStart, .sck, .sdi, .sdo, .sdoEn, .compAbove,
    .overRange, .underRange, .dacCode, .trackEn, .convPowerEn, .busy, .convDone, .cfgWord, .resultCode);
  sarcc_host i_host (.clk, .busy, .sdo, .convertStart, .sck, .sdi);

  initial begin
    forever #25 clk = ~clk;
  end
  // ==========================================
  // model and checking
  function automatic logic [13:0] model(int s, bit ovr, bit und, logic [13:0] cfg);
    if (ovr) return cfg[CFG_RANGE_BIT] ? 14'h3fff : 14'h1fff;
    if (und) return cfg[CFG_RANGE_BIT] ? 14'h0000 : 14'h2000;
    return cfg[CFG_RANGE_BIT] ? s[13:0] : s[13:0] ^ 14'h2000;
  endfunction : model
  task automatic chk(input string what, input logic [27:0] seen, input logic [27:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic results;
    if (num_errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results
  // hang guard, well above forty frames
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      results();
    end
  end
  // ==========================================
  // main sequence
  initial begin
    overRange = 1'b0;
    underRange = 1'b0;
    sample = 0;
    void'($urandom(34942));
    repeat (20) @(posedge clk);
    chk("reset flags", {busy, trackEn, sdoEn, convDone, convPowerEn, cfgWord}, {5'b01000, CFG_RESET});
    chk("reset result", resultCode, 14'h0000);
    #2 rst_n = 1'b1;
    i_host.tick(2);
    prevRes = 14'h0000;
    cfgPrev = CFG_RESET;
    cfgCur = CFG_RESET;
    for (i = 0; i < 40; i++) begin
      hold = 1'($urandom % 2);
      sample = (i == 1) ? 16383 : (i == 2) ? 0 : $urandom % 16384;
      overRange = ($urandom % 6) == 0;
      underRange = ($urandom % 6) == 0;
      nextCfg = 14'($urandom);
      expRes = model(sample, overRange, underRange, cfgCur);
      expQ.push_back(expRes);
      i_host.startConv(ok);
      chk("start", ok, 1);
      if (hold) begin
        i_host.tick(4);
        chk("busy flag", {sdoEn, sdo}, 2'b10);
        i_host.waitDone(ok);
        i_host.tick(2);
        chk("busy end", {sdoEn, sdo}, 2'b11);
        rdExp = {expRes, cfgCur[0] ? 14'h0000 : cfgCur};
      end else begin
        rdExp = {prevRes, cfgPrev[0] ? 14'h0000 : cfgPrev};
      end
      i_host.frame(nextCfg, rd);
      chk("frame", rd, rdExp);
      i_host.waitDone(ok);
      chk("done", ok, 1);
      chk("result", resultCode, expQ.pop_front());
      chk("config", cfgWord, nextCfg);
      cfgPrev = cfgCur;
      cfgCur = nextCfg;
      prevRes = expRes;
    end
    // second reset after the last of the forty conversions
    rst_n = 1'b0;
    i_host.tick(2);
    chk("rereset", {resultCode, cfgWord}, {14'h0000, CFG_RESET});
    rst_n = 1'b1;
    i_host.tick(4);
    chk("after rereset", {busy, trackEn, convPowerEn}, 3'b010);
    results();
  end
endmodule : sar_conversion_control_tb_top
